// file: dv/mcfb_sw_source.sv
`default_nettype none
module mcfb_sw_source (
  // Clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 arst_n_i,
  // Bench control
  input  wire logic                 en_i,
  // Stream towards the controller
  input  wire logic                 sw_ready_i,
  output var  logic                 sw_valid_o,
  output var  mcfb_pkg::mcfb_pair_s sw_o,
  output var  logic [15:0]          pushed_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        taken;
  logic [15:0] next_idx;
  assign taken    = sw_valid_o && sw_ready_i;
  assign next_idx = pushed_o + {15'h0000, taken};
  // A word is held until ready is seen; between words the data lines invert
  // every cycle so a stale byte cannot pass as fresh.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sw_valid_o <= 1'b0;
      sw_o       <= 16'hFFFF;
      pushed_o   <= 16'h0000;
    end
    else
    begin
      pushed_o <= next_idx;
      if (sw_valid_o && !sw_ready_i)
        sw_valid_o <= 1'b1;
      else if (en_i)
      begin
        sw_valid_o <= 1'b1;
        sw_o       <= {~next_idx[7:0], next_idx[7:0]};
      end
      else
      begin
        sw_valid_o <= 1'b0;
        sw_o       <= ~sw_o;
      end
    end
  end
endmodule : mcfb_sw_source
`default_nettype wire

// file: dv/motion_comp_frame_buffer_ctrl_test.sv
`default_nettype none
`define CHK(got, exp, msg) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("CHECK FAILED at %0t: %s", $time, msg); \
    end \
  end
module motion_comp_frame_buffer_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 sys_clk_i = 1'b0;
  logic                 arst_n_i = 1'b0;
  logic                 split_i = 1'b0;
  logic                 blk_start_i = 1'b0;
  logic                 mv_valid_i = 1'b0;
  mcfb_pkg::mcfb_mv_s   mv_i = 8'h00;
  mcfb_pkg::mcfb_rnd_s  rnd_o;
  logic                 pred_busy_o;
  mcfb_pkg::mcfb_xfer_s xfer_o;
  logic                 sw_valid_i;
  mcfb_pkg::mcfb_pair_s sw_i;
  logic                 sw_ready_o;
  logic                 est_rd_i = 1'b0;
  logic                 est_avail_o;
  logic                 band_vld_o;
  mcfb_pkg::mcfb_band_s band_o;
  logic                 recon_valid_i = 1'b0;
  logic                 recon_last_i = 1'b0;
  logic                 recon_luma_o;
  logic [9:0]           recon_row_o;
  logic                 src_en = 1'b0;
  logic [15:0]          pushed;
  int                   fails = 0;
  int                   cmp_count = 0;
  int                   cyc = 0;

  always #20 sys_clk_i = ~sys_clk_i;

  mcfb_ctrl uut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .split_i(split_i),
    .blk_start_i(blk_start_i), .mv_valid_i(mv_valid_i), .mv_i(mv_i), .rnd_o(rnd_o),
    .pred_busy_o(pred_busy_o), .xfer_o(xfer_o), .sw_valid_i(sw_valid_i), .sw_i(sw_i),
    .sw_ready_o(sw_ready_o), .est_rd_i(est_rd_i), .est_avail_o(est_avail_o),
    .band_vld_o(band_vld_o), .band_o(band_o), .recon_valid_i(recon_valid_i),
    .recon_last_i(recon_last_i), .recon_luma_o(recon_luma_o), .recon_row_o(recon_row_o));

  mcfb_sw_source src (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .en_i(src_en),
    .sw_ready_i(sw_ready_o), .sw_valid_o(sw_valid_i), .sw_o(sw_i), .pushed_o(pushed));

  task automatic give_verdict;
    begin
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask : give_verdict

  // The estimator hands its vector 36 cycles after the next block starts.
  task automatic t_pred(input logic split, input logic [7:0] mv, input int lo_ras,
                        input int hi_ras);
    int   k;
    int   first;
    int   cas_n;
    int   ras_n;
    int   wr_n;
    int   rd_n;
    int   runs;
    logic prev;
    begin
      first = -1;
      cas_n = 0;
      ras_n = 0;
      wr_n = 0;
      rd_n = 0;
      runs = 0;
      prev = 1'b0;
      @(posedge sys_clk_i);
      split_i     <= split;
      blk_start_i <= 1'b1;
      @(posedge sys_clk_i);
      blk_start_i <= 1'b0;
      repeat (35) @(posedge sys_clk_i);
      mv_valid_i <= 1'b1;
      mv_i       <= mv;
      for (k = 1; k <= 90; k++)
      begin
        @(posedge sys_clk_i);
        mv_valid_i <= (k == 10);
        #1;
        if (rnd_o.cas && first < 0)
          first = k;
        if (rnd_o.cas && !prev)
          runs++;
        cas_n += rnd_o.cas;
        prev = rnd_o.cas;
        ras_n += rnd_o.ras;
        wr_n += xfer_o.wr;
        rd_n += xfer_o.rd;
        if (k == 5)
          `CHK(pred_busy_o, 1'b1, "busy not raised after vector")
      end
      `CHK(cas_n, 64, "column strobe count per block")
      `CHK(runs, 1, "column strobes not one burst, or refused vector taken")
      `CHK(first inside {[1:3]}, 1'b1, "first column strobe late")
      `CHK(ras_n >= lo_ras && ras_n <= hi_ras, 1'b1, "row strobe count")
      `CHK(wr_n, 1, "reconstruction transfer count")
      `CHK(rd_n inside {[1:2]}, 1'b1, "window transfer count")
      `CHK(pred_busy_o, 1'b0, "busy stuck high")
    end
  endtask : t_pred

  task automatic t_stream;
    int   k;
    int   pops;
    logic bad;
    begin
      pops = 0;
      bad = 1'b0;
      @(posedge sys_clk_i);
      split_i <= 1'b0;
      src_en  <= 1'b1;
      for (k = 0; k < 200; k++)
      begin
        @(posedge sys_clk_i);
        #1;
        if (!sw_ready_o)
          break;
      end
      repeat (5) @(posedge sys_clk_i);
      #1;
      `CHK(pushed, 16'h0040, "fifo accepted other than 64 words")
      `CHK(sw_ready_o, 1'b0, "ready while fifo full")
      `CHK(est_avail_o, 1'b1, "no data offered while full")
      @(posedge sys_clk_i);
      src_en   <= 1'b0;
      est_rd_i <= 1'b1;
      for (k = 0; k < 200; k++)
      begin
        @(posedge sys_clk_i);
        #1;
        if (band_vld_o)
        begin
          if (band_o.low !== pops[7:0])
            bad = 1'b1;
          pops++;
        end
      end
      `CHK(bad, 1'b0, "window bytes out of order or doubled")
      `CHK(pops, int'(pushed), "pops differ from pushes")
      `CHK(est_avail_o, 1'b0, "data offered while empty")
      @(posedge sys_clk_i);
      est_rd_i <= 1'b0;
    end
  endtask : t_stream

  // Non-split mode: the middle band lags one line of blocks, the upper band two.
  task automatic t_delay;
    int   k;
    int   j;
    logic bad;
    begin
      j = int'(pushed);
      bad = 1'b0;
      @(posedge sys_clk_i);
      split_i  <= 1'b0;
      src_en   <= 1'b1;
      est_rd_i <= 1'b1;
      for (k = 0; k < 12000 && j < 11600; k++)
      begin
        @(posedge sys_clk_i);
        #1;
        if (band_vld_o)
        begin
          if (band_o.low !== j[7:0] || (j >= 5760 && band_o.mid !== (j[7:0] ^ 8'h80)) ||
              (j >= 11520 && band_o.up !== j[7:0]))
            bad = 1'b1;
          j++;
        end
      end
      @(posedge sys_clk_i);
      src_en <= 1'b0;
      repeat (8) @(posedge sys_clk_i);
      est_rd_i <= 1'b0;
      `CHK(bad, 1'b0, "delay line bands wrong")
      `CHK(j, 11600, "delay stream stalled")
    end
  endtask : t_delay

  // Split mode: the field bytes trade middle and lower inputs at each line end.
  task automatic t_swap(input int pulses, input logic swapped);
    int         k;
    logic [7:0] e;
    logic       seen;
    begin
      e = pushed[7:0];
      seen = 1'b0;
      @(posedge sys_clk_i);
      split_i     <= 1'b1;
      blk_start_i <= 1'b1;
      repeat (pulses) @(posedge sys_clk_i);
      blk_start_i <= 1'b0;
      src_en      <= 1'b1;
      est_rd_i    <= 1'b1;
      for (k = 0; k < 8 && !seen; k++)
      begin
        @(posedge sys_clk_i);
        #1;
        seen = band_vld_o;
      end
      `CHK(seen, 1'b1, "no band after split-mode read")
      `CHK(band_o.low, swapped ? ~e : e, "lower band field choice")
      `CHK(band_o.mid, swapped ? e : ~e, "middle band field choice")
      @(posedge sys_clk_i);
      src_en <= 1'b0;
      repeat (8) @(posedge sys_clk_i);
      est_rd_i <= 1'b0;
    end
  endtask : t_swap

  task automatic t_recon(input logic luma);
    int k;
    begin
      for (k = 1; k <= 64; k++)
      begin
        @(posedge sys_clk_i);
        recon_valid_i <= 1'b1;
        recon_last_i  <= (k == 64);
        #1;
        if (k == 20)
          `CHK(sw_ready_o, !luma, "window stream during luma write")
      end
      @(posedge sys_clk_i);
      recon_valid_i <= 1'b0;
      recon_last_i  <= 1'b0;
      @(posedge sys_clk_i);
      #1;
      `CHK(recon_luma_o, !luma, "buffer choice did not alternate")
    end
  endtask : t_recon

  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      $display("CHECK FAILED at %0t: run did not finish in time", $time);
      give_verdict();
    end
  end

  initial
  begin
    repeat (7) @(posedge sys_clk_i);
    #1;
    `CHK(rnd_o, 22'h000000, "random port not idle in reset")
    `CHK(xfer_o, 12'h000, "transfer not idle in reset")
    `CHK(sw_ready_o, 1'b1, "ready value in reset")
    `CHK(recon_luma_o, 1'b1, "first block not luma")
    `CHK(recon_row_o, 10'h360, "write base not after current frame")
    @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    t_pred(1'b0, 8'h32, 16, 19);
    t_pred(1'b1, 8'h00, 1, 8);
    t_pred(1'b1, 8'hDE, 1, 8);
    t_stream();
    t_delay();
    // Three blocks have started, so 86 more reach the last column and one more ends the line.
    t_swap(86, 1'b0);
    t_swap(1, 1'b1);
    t_recon(1'b1);
    t_recon(1'b0);
    give_verdict();
  end
endmodule : motion_comp_frame_buffer_ctrl_test
`undef CHK
`default_nettype wire

// file: shared/mcfb_consts.svh
`ifndef MCFB_CONSTS_SVH
`define MCFB_CONSTS_SVH
`define MCFB_BLK_COLS_LAST  7'd89
`define MCFB_BLK_LINES_LAST 7'd71
`define MCFB_ROWS_PER_LINE  10'd12
`define MCFB_ROWS_USED      10'd864
`define MCFB_MEM_ROWS       11'd1024
`define MCFB_BLK_PER_ROW    11'd8
`define MCFB_RECON_LAG      11'd92
`define MCFB_BLK_LAST       6'd63
`define MCFB_DL_LEN         13'd5760
`define MCFB_DL_RELOAD      13'd5759
`define MCFB_DL_WORDS       8192
`define MCFB_FIFO_DEPTH     64
`define MCFB_SW_SHIFT       11'd7
`define MCFB_BLK_W          11'd8
`endif

// file: shared/mcfb_pkg.sv
`default_nettype none
package mcfb_pkg;
  typedef struct packed {
    logic signed [3:0] dx;
    logic signed [3:0] dy;
  } mcfb_mv_s;
  typedef struct packed {
    logic [9:0] row;
    logic [8:0] col;
  } mcfb_addr_s;
  typedef struct packed {
    logic       ras;
    logic       cas;
    logic       odd;
    mcfb_addr_s a;
  } mcfb_rnd_s;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [9:0] row;
  } mcfb_xfer_s;
  typedef struct packed {
    logic [7:0] odd;
    logic [7:0] even;
  } mcfb_pair_s;
  typedef struct packed {
    logic [7:0] up;
    logic [7:0] mid;
    logic [7:0] low;
  } mcfb_band_s;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_XFER = 3'b100
  } mcfb_st_e;
endpackage : mcfb_pkg
`default_nettype wire

// file: verilog/mcfb_ctrl.sv
`include "mcfb_consts.svh"
// Contract
// - Reconstructed blocks go alternately to luminance and chrominance buffers.
// - Idle luminance serial port streams search window at 2f through 64-word FIFO.
// - Each buffer is a 1024x512 byte array; a block sits in one row.
// - Eight consecutive 64-sample blocks fill one 512-byte row in picture order.
// - Picture is 90x72 blocks; twelve rows per line of blocks; 864 rows.
// - Upper band, and middle band when not split, come from delay lines of 5760 bytes.
// - Each sample taken, the delay line reads the address, then writes it.
// - Delay address counts down and reloads with the line length minus one at zero.
// - A block is overwritten only after one line plus two blocks.
// - New frame is written right after the current one, addresses wrap.
// - Free memory must exceed the reconstruction delay.
// - Predicted blocks read at rate f using fast page mode.
// - Prediction output column by column, two page opens per column.
// - Up to three array/serial transfers per predicted block read.
// - Window fetched seven columns right; second transfer when pages differ.
// - Even/odd arrangement keeps even and odd lines of blocks apart.
// - Columns chosen by field multiplexer; each field changes page rarely.
// - Field to middle/lower band mapping swaps at every new line in split mode.
`default_nettype none
module mcfb_ctrl (
  // Clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 arst_n_i,
  // Configuration
  input  wire logic                 split_i,
  // Reference timing and motion vector
  input  wire logic                 blk_start_i,
  input  wire logic                 mv_valid_i,
  input  wire mcfb_pkg::mcfb_mv_s   mv_i,
  // Random port and transfers
  output var  mcfb_pkg::mcfb_rnd_s  rnd_o,
  output var  logic                 pred_busy_o,
  output var  mcfb_pkg::mcfb_xfer_s xfer_o,
  // Search window serial stream
  input  wire logic                 sw_valid_i,
  input  wire mcfb_pkg::mcfb_pair_s sw_i,
  output var  logic                 sw_ready_o,
  // Estimator side
  input  wire logic                 est_rd_i,
  output var  logic                 est_avail_o,
  output var  logic                 band_vld_o,
  output var  mcfb_pkg::mcfb_band_s band_o,
  // Reconstruction serial writes
  input  wire logic                 recon_valid_i,
  input  wire logic                 recon_last_i,
  output var  logic                 recon_luma_o,
  output var  logic [9:0]           recon_row_o
);

  function automatic mcfb_pkg::mcfb_addr_s addr_of(
    input logic [10:0] px,
    input logic [9:0]  py,
    input logic        split,
    input logic [9:0]  base
  );
    logic [6:0] ln;
    ln = split ? {1'b0, py[9:4]} : py[9:3];
    addr_of.row = base + 10'(ln) * `MCFB_ROWS_PER_LINE + 10'(px[10:6]);
    addr_of.col = {px[5:0], py[2:0]};
  endfunction : addr_of

  function automatic logic [13:0] step_pos(input logic [6:0] x, input logic [6:0] y);
    if (x != `MCFB_BLK_COLS_LAST)
      step_pos = {y, x + 7'd1};
    else if (y != `MCFB_BLK_LINES_LAST)
      step_pos = {y + 7'd1, 7'd0};
    else
      step_pos = 14'h0000;
  endfunction : step_pos

  // Block positions, field swap and reconstruction placement.
  logic [6:0] bx_r, by_r, pbx_r, pby_r, rbx_r, rby_r;
  logic [6:0] bx_nxt, by_nxt, pbx_nxt, pby_nxt, rbx_nxt, rby_nxt;
  logic       swap_r, rluma_r, rbusy_r, swap_nxt, rluma_nxt, rbusy_nxt;
  logic [9:0] base_r, rrow_r, base_nxt, rrow_nxt;
  mcfb_pkg::mcfb_addr_s raddr;

  always_comb
  begin
    {by_nxt, bx_nxt} = {by_r, bx_r};
    {pby_nxt, pbx_nxt} = {pby_r, pbx_r};
    {rby_nxt, rbx_nxt} = {rby_r, rbx_r};
    swap_nxt = swap_r;
    rluma_nxt = rluma_r;
    rbusy_nxt = rbusy_r;
    base_nxt = base_r;
    if (blk_start_i)
    begin
      {pby_nxt, pbx_nxt} = {by_r, bx_r};
      {by_nxt, bx_nxt} = step_pos(bx_r, by_r);
      if (bx_r == `MCFB_BLK_COLS_LAST)
        swap_nxt = !swap_r;
    end
    if (recon_valid_i)
      rbusy_nxt = 1'b1;
    if (recon_valid_i && recon_last_i)
    begin
      rbusy_nxt = 1'b0;
      rluma_nxt = !rluma_r;
      if (!rluma_r)
      begin
        {rby_nxt, rbx_nxt} = step_pos(rbx_r, rby_r);
        // The finished frame becomes the one read for prediction.
        if ({rby_nxt, rbx_nxt} == 14'h0000)
          base_nxt = base_r + `MCFB_ROWS_USED;
      end
    end
    // Writing just past the current frame keeps old blocks alive long enough.
    raddr = addr_of(11'({rbx_nxt, 3'b000}), {rby_nxt, 3'b000}, split_i,
                    base_nxt + `MCFB_ROWS_USED);
    rrow_nxt = raddr.row;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      {bx_r, by_r, pbx_r, pby_r, rbx_r, rby_r} <= '0;
      {swap_r, rbusy_r} <= 2'b00;
      rluma_r <= 1'b1;
      base_r <= 10'h000;
      rrow_r <= `MCFB_ROWS_USED;
    end
    else
    begin
      {bx_r, by_r, pbx_r, pby_r} <= {bx_nxt, by_nxt, pbx_nxt, pby_nxt};
      {rbx_r, rby_r, swap_r} <= {rbx_nxt, rby_nxt, swap_nxt};
      {rluma_r, rbusy_r} <= {rluma_nxt, rbusy_nxt};
      base_r <= base_nxt;
      rrow_r <= rrow_nxt;
    end
  end

  assign recon_luma_o = rluma_r;
  assign recon_row_o = rrow_r;

  // Predicted block reader on the random port.
  mcfb_pkg::mcfb_st_e   st_r, st_nxt;
  mcfb_pkg::mcfb_mv_s   mv_r, mv_nxt;
  mcfb_pkg::mcfb_rnd_s  rnd_r, rnd_nxt;
  mcfb_pkg::mcfb_xfer_s xf_r, xf_nxt;
  mcfb_pkg::mcfb_addr_s pa, sw0, sw1;
  logic [6:0]  qx_r, qy_r, qx_nxt, qy_nxt;
  logic [5:0]  cnt_r, cnt_nxt;
  logic [1:0]  slot_r, slot_nxt, ok_r, ok_nxt;
  logic [9:0]  lrow_r [2];
  logic [9:0]  lrow_nxt [2];
  logic [10:0] px, swx;
  logic [9:0]  py;
  logic        fld, ras;

  always_comb
  begin
    st_nxt = st_r;
    mv_nxt = mv_r;
    {qx_nxt, qy_nxt} = {qx_r, qy_r};
    cnt_nxt = cnt_r;
    slot_nxt = slot_r;
    ok_nxt = ok_r;
    lrow_nxt = lrow_r;
    rnd_nxt = '0;
    xf_nxt = '0;
    px = 11'({qx_r, 3'b000}) + {{7{mv_r.dx[3]}}, mv_r.dx} + 11'(cnt_r[5:3]);
    py = 10'({qy_r, 3'b000}) + {{6{mv_r.dy[3]}}, mv_r.dy} + 10'(cnt_r[2:0]);
    pa = addr_of(px, py, split_i, base_r);
    fld = split_i & py[3];
    ras = !ok_r[fld] || (lrow_r[fld] != pa.row);
    swx = 11'({qx_r, 3'b000}) + `MCFB_SW_SHIFT;
    sw0 = addr_of(swx, {qy_r, 3'b000}, split_i, base_r);
    sw1 = addr_of(swx + `MCFB_BLK_W, {qy_r, 3'b000}, split_i, base_r);
    unique case (st_r)
      mcfb_pkg::ST_IDLE:
        if (mv_valid_i)
        begin
          mv_nxt = mv_i;
          {qx_nxt, qy_nxt} = {pbx_r, pby_r};
          cnt_nxt = 6'h00;
          ok_nxt = 2'b00;
          st_nxt = mcfb_pkg::ST_READ;
        end
      mcfb_pkg::ST_READ:
      begin
        rnd_nxt = '{ras: ras, cas: 1'b1, odd: fld, a: pa};
        lrow_nxt[fld] = pa.row;
        ok_nxt[fld] = 1'b1;
        cnt_nxt = cnt_r + 6'h01;
        slot_nxt = 2'h0;
        if (cnt_r == `MCFB_BLK_LAST)
          st_nxt = mcfb_pkg::ST_XFER;
      end
      mcfb_pkg::ST_XFER:
      begin
        slot_nxt = slot_r + 2'h1;
        unique case (slot_r)
          2'h0: xf_nxt = '{wr: 1'b1, rd: 1'b0, row: rrow_r};
          2'h1: xf_nxt = '{wr: 1'b0, rd: 1'b1, row: sw0.row};
          default: xf_nxt = '{wr: 1'b0, rd: sw1.row != sw0.row, row: sw1.row};
        endcase
        if (slot_r == 2'h2)
          st_nxt = mcfb_pkg::ST_IDLE;
      end
      default: st_nxt = mcfb_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_r <= mcfb_pkg::ST_IDLE;
      mv_r <= '0;
      {qx_r, qy_r, cnt_r, slot_r, ok_r} <= '0;
      lrow_r <= '{10'h000, 10'h000};
      rnd_r <= '0;
      xf_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      mv_r <= mv_nxt;
      {qx_r, qy_r, cnt_r, slot_r, ok_r} <= {qx_nxt, qy_nxt, cnt_nxt, slot_nxt, ok_nxt};
      lrow_r <= lrow_nxt;
      rnd_r <= rnd_nxt;
      xf_r <= xf_nxt;
    end
  end

  assign rnd_o = rnd_r;
  assign xfer_o = xf_r;
  assign pred_busy_o = st_r != mcfb_pkg::ST_IDLE;

  // Rate-adaptation FIFO between the 2f serial stream and the estimator.
  mcfb_pkg::mcfb_pair_s fifo_q [`MCFB_FIFO_DEPTH];
  mcfb_pkg::mcfb_pair_s pd;
  logic [6:0] wp_r, rp_r, wp_nxt, rp_nxt;
  logic       full, empty, push, pop;

  always_comb
  begin
    full = (wp_r[6] != rp_r[6]) && (wp_r[5:0] == rp_r[5:0]);
    empty = wp_r == rp_r;
    sw_ready_o = !full && !(rbusy_r && rluma_r);
    push = sw_valid_i && sw_ready_o;
    pop = est_rd_i && !empty;
    wp_nxt = wp_r + 7'(push);
    rp_nxt = rp_r + 7'(pop);
    pd = fifo_q[rp_r[5:0]];
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      {wp_r, rp_r} <= 14'h0000;
    else
      {wp_r, rp_r} <= {wp_nxt, rp_nxt};
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (push)
      fifo_q[wp_r[5:0]] <= sw_i;
  end

  assign est_avail_o = !empty;

  // Search-window delay lines, advanced by each sample the estimator takes.
  logic [7:0]  dl1_q [`MCFB_DL_WORDS];
  logic [7:0]  dl2_q [`MCFB_DL_WORDS];
  logic [12:0] dl_r, dl_nxt;
  logic [7:0]  lo_s, mi_s, d1o, dl1_in;
  logic [7:0]  d1_r, d2_r, lo_r, mi_r;
  logic        pop_r;

  always_comb
  begin
    lo_s = (split_i && swap_r) ? pd.odd : pd.even;
    mi_s = swap_r ? pd.even : pd.odd;
    d1o = dl1_q[dl_r];
    dl1_in = split_i ? mi_s : lo_s;
    dl_nxt = dl_r;
    if (pop)
      dl_nxt = (dl_r == 13'h0000) ? `MCFB_DL_RELOAD : dl_r - 13'h0001;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      dl_r <= `MCFB_DL_RELOAD;
      pop_r <= 1'b0;
    end
    else
    begin
      dl_r <= dl_nxt;
      pop_r <= pop;
    end
  end

  // The old byte is taken before the new one lands at the same address.
  always_ff @(posedge sys_clk_i)
  begin
    if (pop)
    begin
      d1_r <= d1o;
      d2_r <= dl2_q[dl_r];
      dl1_q[dl_r] <= dl1_in;
      dl2_q[dl_r] <= d1o;
      lo_r <= lo_s;
      mi_r <= mi_s;
    end
  end

  assign band_vld_o = pop_r;
  assign band_o = '{up: split_i ? d1_r : d2_r, mid: split_i ? mi_r : d1_r, low: lo_r};

  // Checks.
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  logic [1:0] ras_col_r;
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      ras_col_r <= 2'h0;
    else if (st_r == mcfb_pkg::ST_READ && cnt_r[2:0] == 3'h0)
      ras_col_r <= 2'(rnd_nxt.ras);
    else
      ras_col_r <= ras_col_r + 2'(rnd_nxt.ras);
  end

  sequence s_rd_start;
    st_r == mcfb_pkg::ST_IDLE && mv_valid_i;
  endsequence
  sequence s_rd_run;
    rnd_o.cas && rnd_o.ras ##63 rnd_o.cas ##1 xfer_o.wr && !rnd_o.cas;
  endsequence

  a_read_burst: assert property (s_rd_start |=> ##1 s_rd_run)
    else $error("predicted read burst not 64 strobes then transfers");
  a_ras_col: assert property (!split_i |-> ras_col_r <= 2'h2)
    else $error("more than two page opens in one column");
  a_fifo_full: assert property (full |-> !sw_ready_o)
    else $error("serial stream accepted while fifo full");
  a_fifo_fill: assert property (push && !pop |=> wp_r - rp_r == $past(wp_r - rp_r) + 7'h01)
    else $error("fifo level did not rise on push");
  a_dl_reload: assert property (pop && dl_r == 13'h0000
    |=> dl_r == `MCFB_DL_LEN - 13'h0001)
    else $error("delay counter did not reload");
  a_dl_down: assert property (pop && dl_r != 13'h0000 |=> dl_r == $past(dl_r) - 13'h0001)
    else $error("delay counter did not step down");
  a_recon_alt: assert property (recon_valid_i && recon_last_i
    |=> recon_luma_o != $past(recon_luma_o))
    else $error("reconstruction buffer did not alternate");
  a_recon_row: assert property (recon_valid_i && !recon_last_i |=> $stable(recon_row_o))
    else $error("block row changed inside a block");
  a_swap_line: assert property (blk_start_i && bx_r == `MCFB_BLK_COLS_LAST
    |=> swap_r != $past(swap_r))
    else $error("field mapping not swapped at new line");
  a_free_area: assert property (
    (`MCFB_MEM_ROWS - 11'(`MCFB_ROWS_USED)) * `MCFB_BLK_PER_ROW > `MCFB_RECON_LAG)
    else $error("free memory smaller than reconstruction delay");
  a_sw_second: assert property (st_r == mcfb_pkg::ST_XFER && slot_r == 2'h2
    |=> xfer_o.rd == (xfer_o.row != $past(sw0.row)))
    else $error("second window transfer wrong");

endmodule : mcfb_ctrl
`default_nettype wire
